// File: pmoc_top.sv
/*
 Command interpreter of a single-phase power unit on the management bus:
 on/off control, fault clearing and alert, output-voltage format and
 setpoint, summary status byte.
 Assumes fault_i and power_ok_i come from power-stage logic on clk; the
 CONTROL pin and the bus pins are asynchronous and are synchronised here.
*/
// How it works
// - Commanded on/off mode holds until a new command or pin change.
// - Command top bits 01 soft-off; 10 with margin 00 turns on.
// - Config bit 0 ignored; shutdown always uses the programmed ramp.
// - Config bit 1 picks control pin polarity: 0 low starts, 1 high.
// - Config bit 2 set makes the control pin required for start.
// - Config bit 3 set makes the command on setting required.
// - With both required, unit runs only while both say on.
// - Clear command wipes every set fault and warning bit.
// - Clear command also releases the alert output.
// - After clearing, operation continues per present configuration.
// - A fault still present is set again at once after clearing.
// - Format byte read-only: exponent in 4:0, bits 7:5 read 000.
// - Setpoint is a 16-bit unsigned mantissa, writable at run time.
// - Summary bit 0 flags a fault not shown in bits 7:1.
// - Summary bit 1 flags a communication fault.
// - Summary bit 2 flags any temperature fault or warning.
// - Summary bits 3,4,5: input UV, output OC, output OV faults.
// - Summary bit 6 set whenever no output power is supplied.
`timescale 1ns/1ps
`default_nettype none
`include "pmoc_defs.svh"

module pmoc_top
   import pmoc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   input  wire logic        ctl_pin_i,
   input  wire logic        power_ok_i,
   input  wire pmoc_fault_s fault_i,
   output var  logic        sda_o,
   output var  logic        sda_oe,
   output var  logic        smbalert_n,
   output var  logic        unit_enable,
   output var  logic [15:0] vout_setpoint
);

   logic [1:0] ctl_sy;
   pmoc_evt_s  evt;
   logic [7:0] rd_byte;
   logic [7:0] op_r;
   logic [7:0] cfg_r;
   logic [7:0] cmd_r;
   logic [7:0] vlo_r;
   logic [1:0] idx_r;
   logic [5:0] sts_r;
   logic [5:0] sts_nxt;
   logic       cmd_rx;
   logic       wr_data;
   logic       clr;
   logic       cml_set;
   logic       pin_on;
   logic       cmd_on;
   logic       en_nxt;

   function automatic logic cmd_known(input logic [7:0] c);
      return c == `PMOC_CMD_OPERATION || c == `PMOC_CMD_ONOFF_CFG ||
             c == `PMOC_CMD_CLEAR     || c == `PMOC_CMD_VOUT_FMT  ||
             c == `PMOC_CMD_VOUT_SET  || c == `PMOC_CMD_SUMMARY;
   endfunction

   function automatic logic op_supported(input logic [7:0] d);
      return d[7:6] == `PMOC_OP_SOFT_OFF ||
             (d[7:6] == `PMOC_OP_ON && d[5:4] == `PMOC_OP_MARGIN_OFF);
   endfunction

   pmoc_link u_link (
      .clk     (clk),
      .rst     (rst),
      .scl_i   (scl_i),
      .sda_i   (sda_i),
      .rd_byte (rd_byte),
      .evt     (evt),
      .sda_oe  (sda_oe)
   );

   // Open-drain data line only ever pulls low
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_sy <= 2'h0;
      end else begin
         ctl_sy <= {ctl_sy[0], ctl_pin_i};
      end
   end

   assign cmd_rx  = evt.byte_rx & evt.first;
   assign wr_data = evt.byte_rx & ~evt.first;
   assign clr     = cmd_rx & (evt.data == `PMOC_CMD_CLEAR);

   // Command byte and byte index within the transaction
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cmd_r <= 8'h00;
         idx_r <= 2'h0;
      end else if (cmd_rx) begin
         cmd_r <= evt.data;
         idx_r <= 2'h0;
      end else if ((wr_data || evt.rd_load) && idx_r != 2'h3) begin
         idx_r <= idx_r + 2'h1;
      end
   end

   // Unsupported codes are refused, so the last valid mode stays
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_r <= `PMOC_OP_RST;
      end else if (wr_data && cmd_r == `PMOC_CMD_OPERATION &&
                   idx_r == 2'h0 && op_supported(evt.data)) begin
         op_r <= evt.data;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_r <= `PMOC_CFG_RST;
      end else if (wr_data && cmd_r == `PMOC_CMD_ONOFF_CFG &&
                   idx_r == 2'h0) begin
         cfg_r <= evt.data;
      end
   end

   // Low byte first; the setpoint changes only when both have arrived
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vlo_r         <= 8'h00;
         vout_setpoint <= `PMOC_VOUT_RST;
      end else if (wr_data && cmd_r == `PMOC_CMD_VOUT_SET) begin
         if (idx_r == 2'h0) begin
            vlo_r <= evt.data;
         end else if (idx_r == 2'h1) begin
            vout_setpoint <= {evt.data, vlo_r};
         end
      end
   end

   // Setpoint range is the host's duty; no clamp here

   // Config bit 0 has no effect; the stage always ramps down
   assign pin_on = cfg_r[`PMOC_CFG_POL_BIT] ? ctl_sy[1] : ~ctl_sy[1];
   assign cmd_on = op_r[7:6] == `PMOC_OP_ON;
   assign en_nxt = (~cfg_r[`PMOC_CFG_PIN_BIT] | pin_on) &
                   (~cfg_r[`PMOC_CFG_CMD_BIT] | cmd_on);

   // Follows pin and command levels, so clearing faults never stops it
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unit_enable <= 1'b0;
      end else begin
         unit_enable <= en_nxt;
      end
   end

   assign cml_set = (cmd_rx & ~cmd_known(evt.data)) |
                    (wr_data & (cmd_r == `PMOC_CMD_VOUT_FMT ||
                                cmd_r == `PMOC_CMD_SUMMARY ||
                                (cmd_r == `PMOC_CMD_OPERATION &&
                                 !op_supported(evt.data))));

   // Live conditions win over the clear
   always_comb begin
      sts_nxt = clr ? 6'h00 : sts_r;
      sts_nxt = sts_nxt | {fault_i.vout_ov, fault_i.iout_oc,
                           fault_i.vin_uv, fault_i.temp,
                           cml_set, fault_i.other};
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sts_r      <= 6'h00;
         smbalert_n <= 1'b1;
      end else begin
         sts_r      <= sts_nxt;
         smbalert_n <= ~|sts_nxt;
      end
   end

   always_comb begin
      case (cmd_r)
         `PMOC_CMD_OPERATION: rd_byte = op_r;
         `PMOC_CMD_ONOFF_CFG: rd_byte = cfg_r;
         `PMOC_CMD_VOUT_FMT:  rd_byte = {`PMOC_OUTPUT_VOLTAGE_FORMAT, `PMOC_VOUT_EXP};
         `PMOC_CMD_VOUT_SET:  rd_byte = (idx_r == 2'h0) ?
                                        vout_setpoint[7:0] :
                                        vout_setpoint[15:8];
         `PMOC_CMD_SUMMARY:   rd_byte = {1'b0, ~power_ok_i, sts_r};
         default:             rd_byte = `PMOC_RD_IDLE;
      endcase
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   AST_OP_HOLD: assert property (
      !(wr_data && cmd_r == `PMOC_CMD_OPERATION) |=> $stable(op_r))
      else $error("operation byte changed without a write");

   AST_SOFT_OFF: assert property (
      cfg_r[`PMOC_CFG_CMD_BIT] && op_r[7:6] == `PMOC_OP_SOFT_OFF
      |=> !unit_enable)
      else $error("unit enabled while commanded soft off");

   AST_POLARITY: assert property (
      cfg_r[3:1] == 3'b011 && $stable(cfg_r) && !ctl_sy[1]
      |=> !unit_enable)
      else $error("active high pin low but unit enabled");

   AST_PIN_IGNORED: assert property (
      cfg_r[3:2] == 2'b00 && $stable(cfg_r) |=> unit_enable)
      else $error("unit off with both sources ignored");

   AST_BOTH_ON: assert property (
      cfg_r[3:2] == 2'b11 && !(pin_on && cmd_on) |=> !unit_enable)
      else $error("unit on without both sources on");

   AST_CLEAR: assert property (
      clr && fault_i == '0 |=> sts_r == 6'h00)
      else $error("clear left a status bit set");

   AST_ALERT_FREE: assert property (
      clr && fault_i == '0 |=> smbalert_n ##1 smbalert_n || |sts_r)
      else $error("alert not released by clear");

   AST_RESET_AGAIN: assert property (
      clr && fault_i.temp |=> sts_r[2] && !smbalert_n)
      else $error("present fault lost at clear");

   AST_FMT: assert property (
      cmd_r == `PMOC_CMD_VOUT_FMT |-> rd_byte[7:5] == 3'b000)
      else $error("format byte mode field not linear");

   AST_SETPOINT: assert property (
      wr_data && cmd_r == `PMOC_CMD_VOUT_SET && idx_r == 2'h1
      |=> vout_setpoint == {$past(evt.data), vlo_r})
      else $error("setpoint not taken from the two bytes");

   AST_OFF_BIT: assert property (
      cmd_r == `PMOC_CMD_SUMMARY |-> rd_byte[6] == !power_ok_i && !rd_byte[7])
      else $error("summary off or busy bit wrong");

   AST_STS_MAP: assert property (
      fault_i.iout_oc && !fault_i.vout_ov |=> sts_r[4] ##1 sts_r[4] || clr)
      else $error("output over-current not flagged");

   AST_ACTIVE_LOW: assert property (
      cfg_r[3:1] == 3'h2 && ctl_sy[1] |=> !unit_enable)
      else $error("active low pin high but unit enabled");

   AST_CMD_IGNORED: assert property (
      cfg_r[3:2] == 2'h1 && pin_on |=> unit_enable)
      else $error("unit off although command setting is ignored");

   AST_ON_TAKEN: assert property (
      wr_data && cmd_r == `PMOC_CMD_OPERATION && idx_r == 2'h0 &&
      evt.data[7:4] == 4'h8 |=> op_r[7:6] == `PMOC_OP_ON)
      else $error("supported on code not taken");

   AST_OP_REFUSED: assert property (
      wr_data && cmd_r == `PMOC_CMD_OPERATION && evt.data[7:6] == 2'h2 &&
      evt.data[5:4] != 2'h0 |=> $stable(op_r) && sts_r[1])
      else $error("margin code accepted");

   AST_CLR_KEEPS_RUN: assert property (
      clr && unit_enable && en_nxt |=> unit_enable)
      else $error("clear stopped a running unit");

   AST_CML_FLAG: assert property (
      cml_set |=> sts_r[1] && !smbalert_n)
      else $error("communication fault not flagged");

   AST_TEMP_FLAG: assert property (
      fault_i.temp |=> sts_r[2])
      else $error("temperature fault not flagged");

   AST_OTHER_FLAG: assert property (
      fault_i.other |=> sts_r[0])
      else $error("other fault not flagged");

   AST_VIN_FLAG: assert property (
      fault_i.vin_uv |=> sts_r[3])
      else $error("input under-voltage not flagged");

   AST_OV_FLAG: assert property (
      fault_i.vout_ov |=> sts_r[5])
      else $error("output over-voltage not flagged");

endmodule

`default_nettype wire

// File: pmoc_defs.svh
/*
 Constants of the power-unit command block: command codes, register
 field positions, reset values and the fixed bus address.
 Assumes inclusion by bare name from every design file that needs them.
*/
`ifndef PMOC_DEFS_SVH
`define PMOC_DEFS_SVH

// Bus address of this unit, arbitrary value
`define PMOC_SLAVE_ADDR      7'h10

`define PMOC_CMD_OPERATION   8'h01
`define PMOC_CMD_ONOFF_CFG   8'h02
`define PMOC_CMD_CLEAR       8'h03
`define PMOC_CMD_VOUT_FMT    8'h20
`define PMOC_CMD_VOUT_SET    8'h21
`define PMOC_CMD_SUMMARY     8'h78

`define PMOC_OP_SOFT_OFF     2'h1
`define PMOC_OP_ON           2'h2
`define PMOC_OP_MARGIN_OFF   2'h0

`define PMOC_CFG_POL_BIT     1
`define PMOC_CFG_PIN_BIT     2
`define PMOC_CFG_CMD_BIT     3

`define PMOC_OP_RST          8'h40
`define PMOC_CFG_RST         8'h16
`define PMOC_VOUT_RST        16'h0000

`define PMOC_OUTPUT_VOLTAGE_FORMAT       3'h0
`define PMOC_VOUT_EXP        5'h14

`define PMOC_RD_IDLE         8'hFF

`endif

// File: pmoc_pkg.sv
/*
 Types of the power-unit command block: link states and the structs
 that carry fault levels and link events.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pmoc_pkg;

   typedef enum logic [2:0] {
      LK_IDLE = 3'b000,
      LK_ADDR = 3'b001,
      LK_ACK  = 3'b010,
      LK_RX   = 3'b011,
      LK_TX   = 3'b100,
      LK_TACK = 3'b101
   } pmoc_link_e;

   typedef struct packed {
      logic other;
      logic temp;
      logic vin_uv;
      logic iout_oc;
      logic vout_ov;
   } pmoc_fault_s;

   typedef struct packed {
      logic       byte_rx;
      logic       first;
      logic       rd_load;
      logic       stop;
      logic [7:0] data;
   } pmoc_evt_s;

endpackage

// File: pmoc_link.sv
/*
 Byte engine of the two-wire management bus: start/stop detection,
 address match, receive with acknowledge, transmit of read bytes.
 Assumes scl_i and sda_i are raw pins, sampled here on clk, with SCL
 slow enough for several clk periods per level. No clock stretching.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmoc_defs.svh"

module pmoc_link
   import pmoc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   input  wire logic [7:0] rd_byte,
   output var  pmoc_evt_s  evt,
   output var  logic       sda_oe
);

   logic [1:0] scl_sy;
   logic [1:0] sda_sy;
   logic       scl_q;
   logic       sda_q;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   pmoc_link_e st_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   logic [7:0] tx_r;
   logic       rw_r;
   logic       nack_r;
   logic       first_r;

   // Edge logic only reads the second stage and its delayed copy
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         scl_q  <= 1'b1;
         sda_q  <= 1'b1;
      end else begin
         scl_sy <= {scl_sy[0], scl_i};
         sda_sy <= {sda_sy[0], sda_i};
         scl_q  <= scl_sy[1];
         sda_q  <= sda_sy[1];
      end
   end

   assign rise  = scl_sy[1] & ~scl_q;
   assign fall  = ~scl_sy[1] & scl_q;
   assign start = scl_sy[1] & scl_q & sda_q & ~sda_sy[1];
   assign stop  = scl_sy[1] & scl_q & ~sda_q & sda_sy[1];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r    <= LK_IDLE;
         cnt_r   <= 4'h0;
         sh_r    <= 8'h00;
         tx_r    <= 8'h00;
         rw_r    <= 1'b0;
         nack_r  <= 1'b0;
         first_r <= 1'b0;
         sda_oe  <= 1'b0;
         evt     <= '0;
      end else begin
         evt.byte_rx <= 1'b0;
         evt.rd_load <= 1'b0;
         evt.stop    <= 1'b0;
         if (stop) begin
            st_r     <= LK_IDLE;
            sda_oe   <= 1'b0;
            evt.stop <= 1'b1;
         end else if (start) begin
            st_r    <= LK_ADDR;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
            first_r <= 1'b1;
         end else begin
            unique case (st_r)
               LK_IDLE: begin
               end
               LK_ADDR, LK_RX: begin
                  if (rise) begin
                     sh_r  <= {sh_r[6:0], sda_sy[1]};
                     cnt_r <= cnt_r + 4'h1;
                  end else if (fall && cnt_r == 4'h8) begin
                     if (st_r == LK_RX) begin
                        evt.byte_rx <= 1'b1;
                        evt.data    <= sh_r;
                        evt.first   <= first_r;
                        first_r     <= 1'b0;
                        sda_oe      <= 1'b1;
                        rw_r        <= 1'b0;
                        st_r        <= LK_ACK;
                     end else if (sh_r[7:1] == `PMOC_SLAVE_ADDR) begin
                        sda_oe <= 1'b1;
                        rw_r   <= sh_r[0];
                        st_r   <= LK_ACK;
                     end else begin
                        st_r <= LK_IDLE;
                     end
                  end
               end
               LK_ACK: begin
                  if (fall) begin
                     if (rw_r) begin
                        evt.rd_load <= 1'b1;
                        sda_oe      <= ~rd_byte[7];
                        tx_r        <= {rd_byte[6:0], 1'b0};
                        cnt_r       <= 4'h1;
                        st_r        <= LK_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        cnt_r  <= 4'h0;
                        st_r   <= LK_RX;
                     end
                  end
               end
               LK_TX: begin
                  if (fall) begin
                     if (cnt_r == 4'h8) begin
                        sda_oe <= 1'b0;
                        st_r   <= LK_TACK;
                     end else begin
                        sda_oe <= ~tx_r[7];
                        tx_r   <= {tx_r[6:0], 1'b0};
                        cnt_r  <= cnt_r + 4'h1;
                     end
                  end
               end
               LK_TACK: begin
                  if (rise) begin
                     nack_r <= sda_sy[1];
                  end else if (fall) begin
                     if (nack_r) begin
                        st_r <= LK_IDLE;
                     end else begin
                        evt.rd_load <= 1'b1;
                        sda_oe      <= ~rd_byte[7];
                        tx_r        <= {rd_byte[6:0], 1'b0};
                        cnt_r       <= 4'h1;
                        st_r        <= LK_TX;
                     end
                  end
               end
            endcase
         end
      end
   end

endmodule

`default_nettype wire

// File: pmoc_host.sv
/*
 Behavioural bus host for the power-unit command block bench.
 Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmoc_defs.svh"

module pmoc_host (
   output var  logic scl,
   output var  logic sda_m,
   input  wire logic sda_w
);
   // Idle bus stands high; no clock outside frames
   initial begin
      scl = 1'b1;
      sda_m = 1'b1;
   end

   // 200 ns cell; data moves only while clock is low
   // Non-blocking, so a change on a clock edge never races the sampler
   task automatic bit_io(input logic b, output logic r);
      #50 sda_m <= b;
      #50 scl <= 1'b1;
      #50 r = sda_w;
      #50 scl <= 1'b0;
   endtask

   task automatic byte_io(input logic [7:0] b, input logic last,
                          output logic [7:0] r);
      logic a;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], r[i]);
      end
      bit_io(last, a);
   endtask

   task automatic start();
      #50 sda_m <= 1'b1;
      #50 scl <= 1'b1;
      #50 sda_m <= 1'b0;
      #50 scl <= 1'b0;
   endtask

   task automatic stop();
      #50 sda_m <= 1'b0;
      #50 scl <= 1'b1;
      #50 sda_m <= 1'b1;
      #50;
   endtask

   // Command, nw bytes low first, then nr read bytes low first
   task automatic xfer(input logic [7:0] c, input int nw,
                       input logic [15:0] wd, input int nr,
                       output logic [15:0] rd);
      logic [7:0] t;
      rd = 16'h0000;
      start();
      byte_io({`PMOC_SLAVE_ADDR, 1'b0}, 1'b1, t);
      byte_io(c, 1'b1, t);
      for (int i = 0; i < nw; i++) begin
         byte_io(wd[8*i+:8], 1'b1, t);
      end
      if (nr > 0) begin
         start();
         byte_io({`PMOC_SLAVE_ADDR, 1'b1}, 1'b1, t);
         for (int i = 0; i < nr; i++) begin
            byte_io(8'hFF, logic'(i == nr - 1), t);
            rd[8*i+:8] = t;
         end
      end
      stop();
   endtask
endmodule
`default_nettype wire

// File: pmoc_top_bench.sv
/*
 Self-checking bench of the power-unit command block.
 Assumes pmoc_host as bus partner and a pulled-up data wire.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pmoc_defs.svh"

module pmoc_top_bench
   import pmoc_pkg::*;
;
   logic        clk;
   logic        rst;
   logic        ctl_pin_i;
   logic        power_ok_i;
   pmoc_fault_s fault_i;
   wire  logic  scl;
   wire  logic  sda_m;
   wire  logic  sda_w;
   wire  logic  sda_oe;
   wire  logic  sda_o;
   wire  logic  smbalert_n;
   wire  logic  unit_enable;
   wire  logic [15:0] vout_setpoint;
   logic [15:0] rdv;
   int          errors;
   int          check_count;
   int          mp [5] = '{5, 4, 3, 2, 0};

   // Pull-up wins unless a party pulls low
   assign sda_w = sda_m & (~sda_oe | sda_o);

   pmoc_top u_pmoc_top (
      .clk           (clk),
      .rst           (rst),
      .scl_i         (scl),
      .sda_i         (sda_w),
      .ctl_pin_i     (ctl_pin_i),
      .power_ok_i    (power_ok_i),
      .fault_i       (fault_i),
      .sda_o         (sda_o),
      .sda_oe        (sda_oe),
      .smbalert_n    (smbalert_n),
      .unit_enable   (unit_enable),
      .vout_setpoint (vout_setpoint)
   );

   pmoc_host u_pmoc_host (
      .scl   (scl),
      .sda_m (sda_m),
      .sda_w (sda_w)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Ends at a falling edge so registered outputs are settled
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d);
      u_pmoc_host.xfer(c, n, d, 0, rdv);
      tk(2);
   endtask

   task automatic rd(input logic [7:0] c, input int n);
      u_pmoc_host.xfer(c, 0, 16'h0000, n, rdv);
   endtask

   task automatic pin(input logic v);
      @(posedge clk) ctl_pin_i <= v;
      tk(5);
   endtask

   initial begin
      #2ms;
      errors++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      ctl_pin_i = 1'b0;
      power_ok_i = 1'b0;
      fault_i = '0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      tk(4);
      chk(smbalert_n, 16'h0001);
      chk(unit_enable, 16'h0000);
      chk(vout_setpoint, `PMOC_VOUT_RST);
      rd(`PMOC_CMD_VOUT_FMT, 1);
      chk(rdv, 16'h0014);
      wr(`PMOC_CMD_VOUT_FMT, 1, 16'h00FF);
      rd(`PMOC_CMD_VOUT_FMT, 1);
      chk(rdv, 16'h0014);
      rd(`PMOC_CMD_SUMMARY, 1);
      chk(rdv, 16'h0042);
      @(posedge clk) power_ok_i <= 1'b1;
      wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
      rd(`PMOC_CMD_SUMMARY, 1);
      chk(rdv, 16'h0000);
      $display("test reset and format done");

      pin(1'b1);
      chk(unit_enable, 16'h0001);
      wr(`PMOC_CMD_ONOFF_CFG, 1, 16'h0005);
      tk(2);
      chk(unit_enable, 16'h0000);
      pin(1'b0);
      chk(unit_enable, 16'h0001);
      wr(`PMOC_CMD_ONOFF_CFG, 1, 16'h0001);
      pin(1'b1);
      chk(unit_enable, 16'h0001);
      $display("test control pin done");

      wr(`PMOC_CMD_ONOFF_CFG, 1, 16'h000C);
      pin(1'b0);
      chk(unit_enable, 16'h0000);
      wr(`PMOC_CMD_OPERATION, 1, 16'h008F);
      chk(unit_enable, 16'h0001);
      wr(`PMOC_CMD_OPERATION, 1, 16'h0090);
      chk(unit_enable, 16'h0001);
      rd(`PMOC_CMD_SUMMARY, 1);
      chk(rdv, 16'h0002);
      pin(1'b1);
      chk(unit_enable, 16'h0000);
      pin(1'b0);
      chk(unit_enable, 16'h0001);
      wr(`PMOC_CMD_OPERATION, 1, 16'h007F);
      chk(unit_enable, 16'h0000);
      wr(`PMOC_CMD_ONOFF_CFG, 1, 16'h0008);
      pin(1'b1);
      chk(unit_enable, 16'h0000);
      wr(`PMOC_CMD_OPERATION, 1, 16'h0080);
      chk(unit_enable, 16'h0001);
      rd(`PMOC_CMD_OPERATION, 1);
      chk(rdv, 16'h0080);
      rd(`PMOC_CMD_ONOFF_CFG, 1);
      chk(rdv, 16'h0008);
      $display("test operation command done");

      // Mantissa near 1.1 V, well inside the 3.6 V ceiling
      wr(`PMOC_CMD_VOUT_SET, 2, 16'h1234);
      chk(vout_setpoint, 16'h1234);
      rd(`PMOC_CMD_VOUT_SET, 2);
      chk(rdv, 16'h1234);
      $display("test setpoint done");

      wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
      rd(8'h55, 1);
      chk(rdv, 16'h00FF);
      rd(`PMOC_CMD_SUMMARY, 1);
      chk(rdv, 16'h0002);
      wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
      for (int i = 0; i < 5; i++) begin
         @(posedge clk) fault_i <= pmoc_fault_s'(5'h01 << i);
         tk(2);
         chk(smbalert_n, 16'h0000);
         @(posedge clk) fault_i <= '0;
         rd(`PMOC_CMD_SUMMARY, 1);
         chk(rdv, 16'h0001 << mp[i]);
         wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
         chk(smbalert_n, 16'h0001);
         rd(`PMOC_CMD_SUMMARY, 1);
         chk(rdv, 16'h0000);
      end
      @(posedge clk) fault_i <= 5'h08;
      tk(2);
      wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
      rd(`PMOC_CMD_SUMMARY, 1);
      chk(rdv, 16'h0004);
      chk(smbalert_n, 16'h0000);
      chk(unit_enable, 16'h0001);
      @(posedge clk) fault_i <= '0;
      wr(`PMOC_CMD_CLEAR, 0, 16'h0000);
      chk(smbalert_n, 16'h0001);
      chk(unit_enable, 16'h0001);
      $display("test faults done");
      give_verdict();
   end
endmodule
`default_nettype wire
